// ==== pcrs_consts.vh ====
// Constants for the program counter and return stack block
`ifndef PCRS_CONSTS_VH
`define PCRS_CONSTS_VH

// ----------------------------------------------------------------------------
// Register map (byte addresses, one word each)
// ----------------------------------------------------------------------------
`define PCRS_ADDR_W          8
`define PCRS_OFF_PC_LOW      8'h00
`define PCRS_OFF_HIGH_LATCH  8'h04
`define PCRS_OFF_UPPER_LATCH 8'h08
`define PCRS_OFF_SP_STATUS   8'h0c
`define PCRS_OFF_TOP_LOW     8'h10
`define PCRS_OFF_TOP_HIGH    8'h14
`define PCRS_OFF_TOP_UPPER   8'h18
`define PCRS_OFF_CTRL        8'h1c
`define PCRS_OFF_PC          8'h20

// ----------------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------------
`define PCRS_SP_FULL_BIT     7
`define PCRS_SP_UNF_BIT      6
`define PCRS_CTRL_SVREN_BIT  0
`define PCRS_CTRL_RESET      1'b1
`define PCRS_PC_W            21
`define PCRS_PTR_W           5
`define PCRS_DEPTH           31
`define PCRS_PTR_MAX         5'h1f
`define PCRS_VEC_RESET       21'h000000
`define PCRS_VEC_HIGH        21'h000008
`define PCRS_VEC_LOW         21'h000018
`define PCRS_MEM_24K         21'h006000
`define PCRS_MEM_32K         21'h008000
`define PCRS_PC_STEP         21'h000002

// ----------------------------------------------------------------------------
// Decoder operation codes
// ----------------------------------------------------------------------------
`define PCRS_OP_W            4
`define PCRS_OP_NONE         4'h0
`define PCRS_OP_STEP         4'h1
`define PCRS_OP_CALL         4'h2
`define PCRS_OP_REL_CALL     4'h3
`define PCRS_OP_GOTO         4'h4
`define PCRS_OP_RETURN       4'h5
`define PCRS_OP_RET_LIT      4'h6
`define PCRS_OP_RET_INT      4'h7
`define PCRS_OP_IRQ_HIGH     4'h8
`define PCRS_OP_IRQ_LOW      4'h9
`define PCRS_OP_PUSH         4'ha
`define PCRS_OP_POP          4'hb
`define PCRS_OP_LOW_WRITE    4'hc
`define PCRS_OP_LOW_READ     4'hd

`endif

// ==== pcrs_core.v ====
// Program counter, return address stack and fast shadow registers
`default_nettype none
`include "pcrs_consts.vh"

// Contract
// - 21-bit byte PC; fetch beyond implemented memory reads all zeros.
// - Reset starts at zero; high interrupt to 0008h, low to 0018h.
// - Implemented memory is 24 or 32 Kbytes, chosen per variant.
// - PC is three bytes; low byte direct, upper bytes written via latches; whole PC readable on the bus at 20h.
// - Writing the low byte loads high and upper bytes from latches.
// - Reading the low byte copies high and upper bytes into latches.
// - PC bit 0 stays zero; sequential execution adds two.
// - Call, relative call and goto load PC directly, latches unused.
// - Calls and interrupts push; returns pop; latches untouched.
// - Stack is 31 entries of 21 bits with a 5-bit pointer.
// - Push increments then stores; pop loads PC then decrements.
// - Reset clears pointer; pointer zero has no storage.
// - Top-of-stack registers show and modify the pointed entry.
// - Full flag sets after 31 pushes; cleared by software or power-on.
// - With fault reset, 31st push stores PC+2, sets full, resets.
// - Without fault reset, pointer reaches 31 and further pushes are dropped.
// - Empty pop loads zero, sets underflow, pointer stays zero.
// - Fault reset enable decides whether full or underflow resets device.
// - Software push stores current PC; software pop only decrements.
// - Pointer register: bit7 full, bit6 underflow, bit5 zero, bits4-0 pointer.
// - Interrupt vectoring loads shadows; fast interrupt return restores.
// - Fast call saves shadows; fast return restores them.
module pcrs_core #(
  parameter MEM_BYTES = `PCRS_MEM_32K
)(
  input  wire        i_clk,
  input  wire        i_reset,
  input  wire        i_por,
  input  wire        i_haddr_sel,
  input  wire [31:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output reg  [31:0] o_hrdata,
  output reg         o_hreadyout,
  output reg         o_hresp,
  input  wire [3:0]  i_op,
  input  wire        i_fast,
  input  wire [20:0] i_target,
  input  wire [7:0]  i_pcl_data,
  input  wire [7:0]  i_status,
  input  wire [7:0]  i_working_register,
  input  wire [7:0]  i_bank_select_register,
  output reg  [20:0] o_pc,
  output reg         o_fetch_zero,
  output reg         o_restore,
  output reg  [7:0]  o_status,
  output reg  [7:0]  o_working_register,
  output reg  [7:0]  o_bank_select_register,
  output reg  [7:0]  o_pc_low_byte,
  output reg         o_stack_reset
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg [20:0] pc_r;
  reg [20:0] pc_nxt;
  reg [7:0]  pc_high_latch_r;
  reg [4:0]  pc_upper_latch_r;
  reg [4:0]  sp_r;
  reg [4:0]  sp_nxt;
  reg        full_r;
  reg        unf_r;
  reg        svren_r;
  reg [7:0]  sh_status_r;
  reg [7:0]  sh_work_r;
  reg [7:0]  sh_bank_r;
  reg [20:0] stk_r [1:31];
  reg        push_w;
  reg        pop_w;
  reg [20:0] push_val;
  reg        fault;
  reg        full_set;
  reg        unf_set;
  reg        wr_ph_r;
  reg        rd_ph_r;
  reg [7:0]  addr_r;
  wire [20:0] top_entry = (sp_r == 5'h00) ? 21'h000000 : stk_r[sp_r];

  wire addr_ok = i_haddr_sel && i_hready && i_htrans[1];
  wire wr_now  = wr_ph_r;
  wire [7:0] wd = i_hwdata[7:0];

  // --------------------------------------------------------------------------
  // Bus write and shadow decode
  // --------------------------------------------------------------------------
  wire wr_high_latch  = wr_now && addr_r == `PCRS_OFF_HIGH_LATCH;
  wire wr_upper_latch = wr_now && addr_r == `PCRS_OFF_UPPER_LATCH;
  wire wr_sp_status   = wr_now && addr_r == `PCRS_OFF_SP_STATUS;
  wire wr_top_low     = wr_now && addr_r == `PCRS_OFF_TOP_LOW;
  wire wr_top_high    = wr_now && addr_r == `PCRS_OFF_TOP_HIGH;
  wire wr_top_upper   = wr_now && addr_r == `PCRS_OFF_TOP_UPPER;
  wire wr_ctrl        = wr_now && addr_r == `PCRS_OFF_CTRL;
  wire shadow_load    = i_op == `PCRS_OP_IRQ_HIGH || i_op == `PCRS_OP_IRQ_LOW ||
                        (i_fast && i_op == `PCRS_OP_CALL);
  wire fast_return    = i_fast && (i_op == `PCRS_OP_RET_INT || i_op == `PCRS_OP_RETURN);

  // --------------------------------------------------------------------------
  // Flow decode
  // --------------------------------------------------------------------------
  always @*
  begin
    pc_nxt   = pc_r + `PCRS_PC_STEP;
    sp_nxt   = sp_r;
    push_w   = 1'b0;
    pop_w    = 1'b0;
    push_val = pc_r + `PCRS_PC_STEP;
    fault    = 1'b0;
    full_set = 1'b0;
    unf_set  = 1'b0;
    case (i_op)
      `PCRS_OP_STEP:      pc_nxt = pc_r + `PCRS_PC_STEP;
      `PCRS_OP_GOTO:      pc_nxt = i_target;
      `PCRS_OP_CALL, `PCRS_OP_REL_CALL:
      begin
        push_w = 1'b1;
        pc_nxt = i_target;
      end
      `PCRS_OP_IRQ_HIGH:
      begin
        push_w = 1'b1;
        pc_nxt = `PCRS_VEC_HIGH;
      end
      `PCRS_OP_IRQ_LOW:
      begin
        push_w = 1'b1;
        pc_nxt = `PCRS_VEC_LOW;
      end
      `PCRS_OP_PUSH:
      begin
        push_w = 1'b1;
        push_val = pc_r;
        pc_nxt = pc_r + `PCRS_PC_STEP;
      end
      `PCRS_OP_RETURN, `PCRS_OP_RET_LIT, `PCRS_OP_RET_INT:
      begin
        pop_w  = 1'b1;
        pc_nxt = top_entry;
      end
      `PCRS_OP_POP:
      begin
        pop_w  = 1'b1;
        pc_nxt = pc_r + `PCRS_PC_STEP;
      end
      `PCRS_OP_LOW_WRITE:
        pc_nxt = {pc_upper_latch_r, pc_high_latch_r, i_pcl_data};
      default:            pc_nxt = pc_r;
    endcase
    if (push_w)
    begin
      if (sp_r == 5'h1e)
      begin
        full_set = 1'b1;
        fault    = svren_r;
        sp_nxt   = svren_r ? 5'h00 : `PCRS_PTR_MAX;
      end
      else if (sp_r == `PCRS_PTR_MAX)
        full_set = 1'b1;
      else
        sp_nxt = sp_r + 5'h01;
    end
    if (pop_w)
    begin
      if (sp_r == 5'h00)
      begin
        unf_set = 1'b1;
        fault   = svren_r;
      end
      else
        sp_nxt = sp_r - 5'h01;
    end
    if (fault)
    begin
      pc_nxt = `PCRS_VEC_RESET;
      sp_nxt = 5'h00;
    end
    pc_nxt[0] = 1'b0;
  end

  // --------------------------------------------------------------------------
  // Program counter and pointer
  // --------------------------------------------------------------------------
  always @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      pc_r <= `PCRS_VEC_RESET;
      sp_r <= 5'h00;
    end
    else
    begin
      pc_r <= pc_nxt;
      if (wr_sp_status && i_op == `PCRS_OP_NONE)
        sp_r <= wd[4:0];
      else
        sp_r <= sp_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Counter latches
  // --------------------------------------------------------------------------
  always @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      pc_high_latch_r  <= 8'h00;
      pc_upper_latch_r <= 5'h00;
    end
    else if (i_op == `PCRS_OP_LOW_READ)
    begin
      pc_high_latch_r  <= pc_r[15:8];
      pc_upper_latch_r <= pc_r[20:16];
    end
    else if (wr_high_latch)
      pc_high_latch_r <= wd;
    else if (wr_upper_latch)
      pc_upper_latch_r <= wd[4:0];
  end

  // --------------------------------------------------------------------------
  // Fast return shadows
  // --------------------------------------------------------------------------
  always @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sh_status_r <= 8'h00;
      sh_work_r   <= 8'h00;
      sh_bank_r   <= 8'h00;
    end
    else if (shadow_load)
    begin
      sh_status_r <= i_status;
      sh_work_r   <= i_working_register;
      sh_bank_r   <= i_bank_select_register;
    end
  end

  // Flags survive device resets; only power-on or software clears them
  always @(posedge i_clk or posedge i_por)
  begin
    if (i_por)
    begin
      full_r  <= 1'b0;
      unf_r   <= 1'b0;
      svren_r <= `PCRS_CTRL_RESET;
    end
    else
    begin
      if (full_set)
        full_r <= 1'b1;
      else if (wr_sp_status && !wd[`PCRS_SP_FULL_BIT])
        full_r <= 1'b0;
      if (unf_set)
        unf_r <= 1'b1;
      else if (wr_sp_status && !wd[`PCRS_SP_UNF_BIT])
        unf_r <= 1'b0;
      if (wr_ctrl)
        svren_r <= wd[`PCRS_CTRL_SVREN_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Stack storage
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 1; g <= `PCRS_DEPTH; g = g + 1)
    begin : g_stk
      wire push_here = push_w && sp_r != `PCRS_PTR_MAX && sp_r + 5'h01 == g;
      wire at_top    = (sp_r == g);
      always @(posedge i_clk or posedge i_reset)
      begin
        if (i_reset)
          stk_r[g] <= 21'h000000;
        else if (push_here)
          stk_r[g] <= push_val;
        else if (at_top && wr_top_low)
          stk_r[g] <= {stk_r[g][20:8], wd};
        else if (at_top && wr_top_high)
          stk_r[g] <= {stk_r[g][20:16], wd, stk_r[g][7:0]};
        else if (at_top && wr_top_upper)
          stk_r[g] <= {wd[4:0], stk_r[g][15:0]};
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // --------------------------------------------------------------------------
  always @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      wr_ph_r <= 1'b0;
      rd_ph_r <= 1'b0;
      addr_r  <= 8'h00;
    end
    else if (i_hready)
    begin
      wr_ph_r <= addr_ok && i_hwrite;
      rd_ph_r <= addr_ok && !i_hwrite;
      addr_r  <= i_haddr[7:0];
    end
  end

  reg [7:0] rd_mux;
  always @*
  begin
    case (i_haddr[7:0])
      `PCRS_OFF_PC_LOW:      rd_mux = pc_r[7:0];
      `PCRS_OFF_HIGH_LATCH:  rd_mux = pc_high_latch_r;
      `PCRS_OFF_UPPER_LATCH: rd_mux = {3'h0, pc_upper_latch_r};
      `PCRS_OFF_SP_STATUS:   rd_mux = {full_r, unf_r, 1'b0, sp_r};
      `PCRS_OFF_TOP_LOW:     rd_mux = top_entry[7:0];
      `PCRS_OFF_TOP_HIGH:    rd_mux = top_entry[15:8];
      `PCRS_OFF_TOP_UPPER:   rd_mux = {3'h0, top_entry[20:16]};
      `PCRS_OFF_CTRL:   rd_mux = {7'h00, svren_r};
      default:          rd_mux = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  always @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_hrdata               <= 32'h00000000;
      o_hreadyout            <= 1'b1;
      o_hresp                <= 1'b0;
      o_pc                   <= `PCRS_VEC_RESET;
      o_fetch_zero           <= 1'b0;
      o_restore              <= 1'b0;
      o_status               <= 8'h00;
      o_working_register     <= 8'h00;
      o_bank_select_register <= 8'h00;
      o_pc_low_byte          <= 8'h00;
      o_stack_reset          <= 1'b0;
    end
    else
    begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      if (addr_ok && !i_hwrite)
      begin
        if (i_haddr[7:0] == `PCRS_OFF_PC)
          o_hrdata <= {11'h000, pc_r};
        else
          o_hrdata <= {24'h000000, rd_mux};
      end
      o_pc          <= pc_nxt;
      o_fetch_zero  <= (pc_nxt >= MEM_BYTES);
      o_pc_low_byte <= pc_nxt[7:0];
      o_stack_reset <= fault;
      o_restore     <= fast_return;
      o_status               <= sh_status_r;
      o_working_register     <= sh_work_r;
      o_bank_select_register <= sh_bank_r;
    end
  end

endmodule // pcrs_core
`default_nettype wire

// ==== pcrs_core_asserts.sv ====
// Port assertions for the program counter and return stack core
`default_nettype none
`include "pcrs_consts.vh"
module pcrs_core_asserts #(
  parameter MEM_BYTES = `PCRS_MEM_32K
)(
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic [3:0]  i_op,
  input wire logic        i_fast,
  input wire logic [20:0] i_target,
  input wire logic [7:0]  i_pcl_data,
  input wire logic [20:0] o_pc,
  input wire logic        o_fetch_zero,
  input wire logic        o_restore,
  input wire logic [7:0]  o_pc_low_byte,
  input wire logic        o_stack_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------
  // Operation classes
  // --------------------
  wire logic brn = i_op == `PCRS_OP_CALL || i_op == `PCRS_OP_REL_CALL || i_op == `PCRS_OP_GOTO;
  wire logic irq = i_op == `PCRS_OP_IRQ_HIGH || i_op == `PCRS_OP_IRQ_LOW;
  wire logic ret = i_op == `PCRS_OP_RETURN || i_op == `PCRS_OP_RET_INT;
  wire logic pclw = i_op == `PCRS_OP_LOW_WRITE;
  // Every op that pushes or pops, goto excluded
  wire logic stk = i_op >= `PCRS_OP_CALL && i_op <= `PCRS_OP_POP && i_op != `PCRS_OP_GOTO;
  wire logic [20:0] vec = i_op == `PCRS_OP_IRQ_HIGH ? `PCRS_VEC_HIGH : `PCRS_VEC_LOW;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  chk_pc_aligned: assert property (!o_pc[0])
    else $error("pc bit 0 set");
  chk_step_two: assert property (i_op == `PCRS_OP_STEP |=> o_pc == $past(o_pc) + 21'h2)
    else $error("step did not add two");
  // A push that faults sends the counter to the reset vector instead
  chk_branch_load: assert property (brn |=> o_stack_reset || o_pc == $past(i_target))
    else $error("branch target not loaded");
  chk_irq_vector: assert property (irq |=> o_stack_reset || o_pc == $past(vec))
    else $error("wrong interrupt vector");
  chk_fetch_zero: assert property (o_fetch_zero == (o_pc >= MEM_BYTES))
    else $error("fetch zero flag wrong");
  chk_low_byte: assert property (o_pc_low_byte == o_pc[7:0])
    else $error("low byte differs from pc");
  chk_pcl_write: assert property (pclw |=> o_pc[7:0] == ($past(i_pcl_data) & 8'hfe))
    else $error("low byte write not applied");
  chk_fast_restore: assert property (ret && i_fast |-> ##[1:2] o_restore)
    else $error("fast return gave no restore");
  chk_fault_cause: assert property (o_stack_reset |-> $past(stk) || $past(stk, 2))
    else $error("stack reset without stack op");
endmodule // pcrs_core_asserts
`default_nettype wire

// ==== pcrs_dec_model.sv ====
// Decoder and interrupt acknowledge model feeding the core operation port
`default_nettype none
`include "pcrs_consts.vh"
module pcrs_dec_model (
  input  wire logic        i_clk,
  output var  logic [3:0]  o_op,
  output var  logic        o_fast,
  output var  logic [20:0] o_target,
  output var  logic [7:0]  o_pcl_data,
  output var  logic [7:0]  o_status,
  output var  logic [7:0]  o_working_register,
  output var  logic [7:0]  o_bank_select_register
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {o_op, o_fast, o_target, o_pcl_data} = '0;
    {o_status, o_working_register, o_bank_select_register} = '0;
  end
  // One op per edge; core registers move with every op so shadows must hold
  // Interrupt ops come only when the bench is off the stack registers
  task automatic issue(input logic [3:0] op, input logic f, input logic [20:0] t,
                       input logic [7:0] d);
    @(posedge i_clk);
    o_op <= op;
    o_fast <= f;
    o_target <= t;
    o_pcl_data <= d;
    o_status <= d;
    o_working_register <= ~d;
    o_bank_select_register <= d ^ 8'h5a;
  endtask
endmodule // pcrs_dec_model
`default_nettype wire

// ==== pcrs_core_tb.sv ====
// Self-checking bench for the program counter and return stack core
`default_nettype none
`include "pcrs_consts.vh"
`define PCRS_CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module pcrs_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] op; logic [20:0] t; logic [20:0] pc;} pcrs_row_t;
  logic        i_clk = 1'b0;
  logic        rst_r = 1'b1;
  logic        i_por = 1'b1;
  logic [1:0]  flt_r = 2'h0;
  logic        i_haddr_sel = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [1:0]  i_htrans = 2'h0;
  logic        i_hwrite = 1'b0;
  logic [31:0] i_hwdata = 32'h0;
  logic [31:0] rd;
  int          mismatches = 0;
  int          total_checks = 0;
  wire logic        i_reset = rst_r | flt_r[1];
  wire logic [31:0] o_hrdata;
  wire logic        o_hreadyout, o_hresp, o_fetch_zero, o_restore, o_stack_reset, i_fast;
  wire logic [20:0] o_pc, i_target;
  wire logic [7:0]  o_status, o_working_register, o_bank_select_register, o_pc_low_byte;
  wire logic [7:0]  i_pcl_data, i_status, i_working_register, i_bank_select_register;
  wire logic [3:0]  i_op;
  pcrs_row_t rows [13] = '{
    '{`PCRS_OP_STEP, 21'h0, 21'h2}, '{`PCRS_OP_STEP, 21'h0, 21'h4},
    '{`PCRS_OP_GOTO, 21'h1234, 21'h1234}, '{`PCRS_OP_CALL, 21'h100, 21'h100},
    '{`PCRS_OP_REL_CALL, 21'h200, 21'h200}, '{`PCRS_OP_IRQ_HIGH, 21'h0, 21'h8},
    '{`PCRS_OP_IRQ_LOW, 21'h0, 21'h18}, '{`PCRS_OP_RET_INT, 21'h0, 21'ha},
    '{`PCRS_OP_RETURN, 21'h0, 21'h202}, '{`PCRS_OP_RET_LIT, 21'h0, 21'h102},
    '{`PCRS_OP_RETURN, 21'h0, 21'h1236}, '{`PCRS_OP_GOTO, 21'h5ffe, 21'h5ffe},
    '{`PCRS_OP_STEP, 21'h0, 21'h6000}};
  always #20 i_clk = ~i_clk;
  // Stack fault pulse fed back as a device reset, two cycles late
  always @(posedge i_clk) flt_r <= {flt_r[0], o_stack_reset};
  pcrs_dec_model dec (.i_clk(i_clk), .o_op(i_op), .o_fast(i_fast), .o_target(i_target),
    .o_pcl_data(i_pcl_data), .o_status(i_status), .o_working_register(i_working_register),
    .o_bank_select_register(i_bank_select_register));
  pcrs_core #(.MEM_BYTES(`PCRS_MEM_24K)) DUT (.i_clk(i_clk), .i_reset(i_reset),
    .i_por(i_por), .i_haddr_sel(i_haddr_sel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_op(i_op),
    .i_fast(i_fast), .i_target(i_target), .i_pcl_data(i_pcl_data), .i_status(i_status),
    .i_working_register(i_working_register), .i_bank_select_register(i_bank_select_register),
    .o_pc(o_pc), .o_fetch_zero(o_fetch_zero), .o_restore(o_restore), .o_status(o_status),
    .o_working_register(o_working_register), .o_pc_low_byte(o_pc_low_byte),
    .o_bank_select_register(o_bank_select_register), .o_stack_reset(o_stack_reset));
  // --------------------
  // Tasks
  // --------------------
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hrdy;
    int n;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (o_hreadyout !== 1'b1 && n < 64);
    if (o_hreadyout !== 1'b1)
    begin
      mismatches++;
      conclude();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_haddr_sel <= 1'b1;
    i_haddr <= {24'h0, a};
    i_htrans <= 2'h2;
    i_hwrite <= w;
    hrdy();
    i_htrans <= 2'h0;
    i_hwdata <= {24'h0, d};
    hrdy();
    rd = o_hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h0);
    `PCRS_CHK(rd, {24'h0, e})
  endtask
  task automatic run(input logic [3:0] o, input logic f, input logic [20:0] t,
                     input logic [7:0] d);
    dec.issue(o, f, t, d);
    dec.issue(`PCRS_OP_NONE, 1'b0, 21'h0, 8'h0);
    #1;
  endtask
  task automatic shadow(input logic [7:0] d);
    int n;
    n = 0;
    while (o_restore !== 1'b1 && n < 4)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    `PCRS_CHK({o_restore, o_status, o_working_register, o_bank_select_register}, {1'b1, d, ~d, d ^ 8'h5a})
  endtask
  // --------------------
  // Main sequence
  // --------------------
  initial
  begin
    repeat (4) @(posedge i_clk);
    rst_r <= 1'b0;
    i_por <= 1'b0;
    rdc(`PCRS_OFF_SP_STATUS, 8'h00);
    `PCRS_CHK({o_hreadyout, o_hresp}, 2'b10)
    rdc(`PCRS_OFF_CTRL, 8'h01);
    bus(1'b1, 8'h30, 8'hff);
    rdc(8'h30, 8'h00);
    foreach (rows[i])
    begin
      run(rows[i].op, 1'b0, rows[i].t, 8'h0);
      `PCRS_CHK(o_pc, rows[i].pc)
    end
    `PCRS_CHK(o_fetch_zero, 1'b1)
    bus(1'b1, `PCRS_OFF_HIGH_LATCH, 8'h12);
    bus(1'b1, `PCRS_OFF_UPPER_LATCH, 8'h03);
    run(`PCRS_OP_LOW_WRITE, 1'b0, 21'h0, 8'h45);
    `PCRS_CHK(o_pc, 21'h031244)
    `PCRS_CHK(o_pc_low_byte, 8'h44)
    run(`PCRS_OP_GOTO, 1'b0, 21'h1ab00, 8'h0);
    run(`PCRS_OP_LOW_READ, 1'b0, 21'h0, 8'h0);
    run(`PCRS_OP_CALL, 1'b0, 21'h400, 8'h0);
    run(`PCRS_OP_RETURN, 1'b0, 21'h0, 8'h0);
    rdc(`PCRS_OFF_HIGH_LATCH, 8'hab);
    rdc(`PCRS_OFF_UPPER_LATCH, 8'h01);
    run(`PCRS_OP_IRQ_HIGH, 1'b0, 21'h0, 8'h3c);
    run(`PCRS_OP_RET_INT, 1'b1, 21'h0, 8'h11);
    shadow(8'h3c);
    run(`PCRS_OP_CALL, 1'b1, 21'h300, 8'h71);
    run(`PCRS_OP_RETURN, 1'b1, 21'h0, 8'h00);
    shadow(8'h71);
    bus(1'b1, `PCRS_OFF_CTRL, 8'h00);
    run(`PCRS_OP_RETURN, 1'b0, 21'h0, 8'h0);
    `PCRS_CHK(o_pc, 21'h0)
    rdc(`PCRS_OFF_SP_STATUS, 8'h40);
    bus(1'b1, `PCRS_OFF_SP_STATUS, 8'h3f);
    rdc(`PCRS_OFF_SP_STATUS, 8'h1f);
    bus(1'b1, `PCRS_OFF_SP_STATUS, 8'h00);
    for (int k = 1; k <= 31; k++)
      dec.issue(`PCRS_OP_CALL, 1'b0, 21'(k << 8), 8'h0);
    run(`PCRS_OP_CALL, 1'b0, 21'h2000, 8'h0);
    rdc(`PCRS_OFF_SP_STATUS, 8'h9f);
    rdc(`PCRS_OFF_TOP_LOW, 8'h02);
    bus(1'b1, `PCRS_OFF_TOP_HIGH, 8'h0a);
    run(`PCRS_OP_RETURN, 1'b0, 21'h0, 8'h0);
    `PCRS_CHK(o_pc, 21'h0a02)
    run(`PCRS_OP_GOTO, 1'b0, 21'h4444, 8'h0);
    run(`PCRS_OP_PUSH, 1'b0, 21'h0, 8'h0);
    rdc(`PCRS_OFF_TOP_HIGH, 8'h44);
    run(`PCRS_OP_POP, 1'b0, 21'h0, 8'h0);
    rdc(`PCRS_OFF_TOP_HIGH, 8'h1d);
    rdc(`PCRS_OFF_SP_STATUS, 8'h9e);
    @(posedge i_clk);
    rst_r <= 1'b1;
    @(posedge i_clk);
    rst_r <= 1'b0;
    rdc(`PCRS_OFF_SP_STATUS, 8'h80);
    `PCRS_CHK(o_pc, 21'h0)
    bus(1'b1, `PCRS_OFF_CTRL, 8'h01);
    bus(1'b1, `PCRS_OFF_SP_STATUS, 8'h1e);
    run(`PCRS_OP_CALL, 1'b0, 21'h500, 8'h0);
    repeat (5) @(posedge i_clk);
    rdc(`PCRS_OFF_SP_STATUS, 8'h80);
    `PCRS_CHK(o_pc, 21'h0)
    bus(1'b1, `PCRS_OFF_SP_STATUS, 8'h00);
    run(`PCRS_OP_RETURN, 1'b0, 21'h0, 8'h0);
    repeat (5) @(posedge i_clk);
    rdc(`PCRS_OFF_SP_STATUS, 8'h40);
    conclude();
  end
endmodule // pcrs_core_tb
bind pcrs_core pcrs_core_asserts #(.MEM_BYTES(MEM_BYTES)) u_chk (.i_clk(i_clk),
  .i_reset(i_reset), .i_op(i_op), .i_fast(i_fast), .i_target(i_target),
  .i_pcl_data(i_pcl_data), .o_pc(o_pc), .o_fetch_zero(o_fetch_zero), .o_restore(o_restore),
  .o_pc_low_byte(o_pc_low_byte), .o_stack_reset(o_stack_reset));
`default_nettype wire
